/* include/adccw_consts.svh */
// Purpose: constants of the converter control word decoder
// Assumes: core clock 25 MHz, link clock from the serial host
// Notes:   field positions, power and test codes, reset values and timing counts only
//
// Summary of operation
// - ten-bit word: address, power pair, common, pair, channel, start, ref
// - word whose address bit mismatches the address pin is discarded whole
// - only the device that took the last word may drive serial data
// - stored package address bit is zero after power-up
// - power codes: 00 down now, 01/10 down after conversion, 11 up
// - equal power bits override end-of-conversion power-down decision
// - common-input select ignored while pair mode is selected
// - single-ended mode connects input n+1 against analog ground
// - common mode connects inputs 1 to 7 against input 8
// - pair mode codes 0 to 3 connect pairs 1/2 to 7/8, odd positive
// - pair mode code 4 feeds half reference, code 5 full reference
// - four-channel variant: two channel bits, common input 4, tests on 2/3
// - software start begins conversion 400 ns after the write
// - channel change in the starting write is the one acquired
// - software start bit clears itself when its conversion ends
// - acquire with comparator balanced, then hold and run the DAC search
// - word latched at the frame, kept until the next valid word
// - every control bit is zero after reset, so fully powered down
// - external reference bit selects the pin, internal reference off
// - result is a 10-bit straight binary code
`ifndef ADCCW_CONSTS_SVH
`define ADCCW_CONSTS_SVH

`define ADCCW_WORD_W        10
`define ADCCW_CTRL_RST      10'h000
`define ADCCW_F_ADDR        9
`define ADCCW_F_PWR_HI      8
`define ADCCW_F_PWR_LO      7
`define ADCCW_F_COMMON      6
`define ADCCW_F_PAIR        5
`define ADCCW_F_CH_HI       4
`define ADCCW_F_CH_LO       2
`define ADCCW_F_START       1
`define ADCCW_F_EXT_VREF_SELECT      0
`define ADCCW_PWR_DOWN_NOW  2'h0
`define ADCCW_PWR_PART_EOC  2'h1
`define ADCCW_PWR_FULL_EOC  2'h2
`define ADCCW_PWR_UP        2'h3
`define ADCCW_RES_W         10
`define ADCCW_RES_MSB       10'h200
`define ADCCW_CLK_NS        40
`define ADCCW_START_NS      400
`define ADCCW_START_CYC     \
    ((`ADCCW_START_NS + `ADCCW_CLK_NS - 1) / `ADCCW_CLK_NS)
`define ADCCW_BIT_CYC       3
`define ADCCW_IN_NONE       4'h0
`define ADCCW_TEST_NONE     2'h0
`define ADCCW_TEST_HALF     2'h1
`define ADCCW_TEST_FULL     2'h2

`endif

/* include/adccw_pkg.sv */
// Purpose: types of the converter control word decoder
// Assumes: adccw_consts.svh supplies widths
// Notes:   one packed state struct per module
`default_nettype none
`include "adccw_consts.svh"
package adccw_pkg;

    // conversion sequencer phases
    typedef enum logic [1:0] {
        SEQ_ACQ,
        SEQ_DELAY,
        SEQ_BIT,
        SEQ_DONE
    } adccw_seq_t;

    // link side state
    typedef struct packed {
        logic [1:0]  rst_sync;
        logic [1:0]  sel_sync;
        logic [2:0]  res_sync;
        logic [3:0]  cnt;
        logic [8:0]  shift;
        logic [9:0]  word;
        logic        word_tgl;
        logic [9:0]  res_hold;
        logic [9:0]  tx;
        logic        dout;
        logic        dout_oe;
    } adccw_link_t;

    // core side state
    typedef struct packed {
        logic [9:0]  ctrl;
        logic        sel;
        logic [2:0]  tgl_sync;
        logic [1:0]  addr_sync;
        logic [1:0]  comp_sync;
        adccw_seq_t  seq;
        logic [3:0]  dly;
        logic [1:0]  settle;
        logic [3:0]  bit_idx;
        logic [9:0]  trial;
        logic [9:0]  result;
        logic        res_tgl;
        logic        hold;
        logic [3:0]  pos;
        logic [3:0]  neg;
        logic [1:0]  test;
        logic        undoc;
        logic        pd_full;
        logic        pd_part;
        logic        ext_ref;
        logic        int_ref_en;
        logic        busy;
    } adccw_core_t;

endpackage
`default_nettype wire

/* design/adccw_link.sv */
// Purpose: serial side of the control port, on the link clock
// Assumes: link clock runs while frame sync is low and during reset
// Notes:   word and its toggle stay put until the next full frame
`timescale 1ns/10ps
`default_nettype none
`include "adccw_consts.svh"
module adccw_link
    import adccw_pkg::*;
(
    // link clock and core reset
    input  wire logic        sclk_i,
    input  wire logic        rst_i,
    // serial pins
    input  wire logic        frame_sync_n_i,
    input  wire logic        sdata_i,
    output logic             sdata_o,
    output logic             sdata_oe_o,
    // core side
    input  wire logic        sel_i,
    input  wire logic [9:0]  result_i,
    input  wire logic        result_tgl_i,
    output logic [9:0]       word_o,
    output logic             word_tgl_o
);

    adccw_link_t l_reg;
    adccw_link_t l_next;

    // shift in the control word, shift out the held result
    always_comb begin
        l_next = l_reg;
        l_next.rst_sync = {l_reg.rst_sync[0], rst_i};
        l_next.sel_sync = {l_reg.sel_sync[0], sel_i};
        l_next.res_sync = {l_reg.res_sync[1:0], result_tgl_i};
        // result is stable long before its toggle arrives here
        if (l_reg.res_sync[2] != l_reg.res_sync[1]) begin
            l_next.res_hold = result_i;
        end
        if (!frame_sync_n_i) begin
            l_next.shift = {l_reg.shift[7:0], sdata_i};
            if (l_reg.cnt == 4'h9) begin
                // tenth bit: word complete inside the frame
                l_next.word     = {l_reg.shift, sdata_i};
                l_next.word_tgl = ~l_reg.word_tgl;
                l_next.cnt      = 4'h0;
            end else begin
                l_next.cnt = l_reg.cnt + 4'h1;
            end
            if (l_reg.cnt == 4'h0) begin
                l_next.dout = l_reg.res_hold[9];
                l_next.tx   = {l_reg.res_hold[8:0], 1'b0};
            end else begin
                l_next.dout = l_reg.tx[9];
                l_next.tx   = {l_reg.tx[8:0], 1'b0};
            end
            l_next.dout_oe = l_reg.sel_sync[1];
        end else begin
            l_next.cnt     = 4'h0;
            l_next.dout_oe = 1'b0;
        end
        if (l_reg.rst_sync[1]) begin
            l_next.cnt      = 4'h0;
            l_next.word     = `ADCCW_CTRL_RST;
            l_next.word_tgl = 1'b0;
            l_next.dout_oe  = 1'b0;
            l_next.dout     = 1'b0;
        end
    end

    always_ff @(posedge sclk_i) begin
        l_reg <= l_next;
    end

    assign sdata_o    = l_reg.dout;
    assign sdata_oe_o = l_reg.dout_oe;
    assign word_o     = l_reg.word;
    assign word_tgl_o = l_reg.word_tgl;

endmodule // adccw_link
`default_nettype wire

/* design/adccw_top.sv */
// Purpose: control word decoder and conversion sequencer of the converter
// Assumes: comparator pin high when sampled input is at or above the DAC
// Notes:   four-channel variant chosen by QUAD, else eight channels
`timescale 1ns/10ps
`default_nettype none
`include "adccw_consts.svh"
module adccw_top
    import adccw_pkg::*;
#(
    parameter bit QUAD = 1'b0
)
(
    // core clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // serial control port
    input  wire logic        sclk_i,
    input  wire logic        frame_sync_n_i,
    input  wire logic        sdata_i,
    output logic             sdata_o,
    output logic             sdata_oe_o,
    // package and analog side inputs
    input  wire logic        package_addr_pin_i,
    input  wire logic        comparator_i,
    // multiplexer and test selection
    output logic [3:0]       mux_pos_o,
    output logic [3:0]       mux_neg_o,
    output logic [1:0]       test_input_o,
    output logic             undoc_select_o,
    // converter core
    output logic             sample_hold_o,
    output logic [9:0]       dac_code_o,
    output logic             conv_busy_o,
    // power and reference
    output logic             full_power_down_o,
    output logic             partial_power_down_o,
    output logic             ext_vref_select_o,
    output logic             int_ref_enable_o
);

    adccw_core_t c_reg;
    adccw_core_t c_next;

    logic [9:0]  link_word;
    logic        link_tgl;

    // serial side lives on the link clock
    adccw_link u_link (
        .sclk_i         (sclk_i),
        .rst_i          (rst_i),
        .frame_sync_n_i (frame_sync_n_i),
        .sdata_i        (sdata_i),
        .sdata_o        (sdata_o),
        .sdata_oe_o     (sdata_oe_o),
        .sel_i          (c_reg.sel),
        .result_i       (c_reg.result),
        .result_tgl_i   (c_reg.res_tgl),
        .word_o         (link_word),
        .word_tgl_o     (link_tgl)
    );

    // decoded channel selection of the stored word
    logic [3:0]  dec_pos;
    logic [3:0]  dec_neg;
    logic [1:0]  dec_test;
    logic        dec_undoc;
    logic [2:0]  chan;
    logic [3:0]  last_in;
    logic [2:0]  half_pairs;
    logic        common_sel;
    logic        pair_sel;

    // field extraction; quad ignores the top channel bit
    always_comb begin
        common_sel = c_reg.ctrl[`ADCCW_F_COMMON];
        pair_sel   = c_reg.ctrl[`ADCCW_F_PAIR];
        if (QUAD) begin
            chan       = {1'b0, c_reg.ctrl[`ADCCW_F_CH_LO+1:`ADCCW_F_CH_LO]};
            last_in    = 4'h4;
            half_pairs = 3'h2;
        end else begin
            chan       = c_reg.ctrl[`ADCCW_F_CH_HI:`ADCCW_F_CH_LO];
            last_in    = 4'h8;
            half_pairs = 3'h4;
        end
    end

    // channel table: single-ended, common input, pairs, tests
    always_comb begin
        dec_pos   = `ADCCW_IN_NONE;
        dec_neg   = `ADCCW_IN_NONE;
        dec_test  = `ADCCW_TEST_NONE;
        dec_undoc = 1'b0;
        if (!pair_sel) begin
            // common select only counts outside pair mode
            dec_pos = {1'b0, chan} + 4'h1;
            if (common_sel) begin
                if (dec_pos == last_in) begin
                    // common input against itself is meaningless
                    dec_pos   = `ADCCW_IN_NONE;
                    dec_undoc = 1'b1;
                end else begin
                    dec_neg = last_in;
                end
            end
        end else if (chan < half_pairs) begin
            dec_pos = {chan, 1'b1};
            dec_neg = {chan, 1'b0} + 4'h2;
        end else if (chan == half_pairs) begin
            dec_test = `ADCCW_TEST_HALF;
        end else if (chan == half_pairs + 3'h1) begin
            dec_test = `ADCCW_TEST_FULL;
        end else begin
            // codes past the tests: connect nothing, raise flag
            dec_undoc = 1'b1;
        end
    end

    // word arrival, power control and conversion sequencer
    logic        new_word;
    logic        addr_ok;
    logic [1:0]  pwr_code;
    logic        keep_bit;

    always_comb begin
        c_next = c_reg;
        new_word = 1'b0;
        addr_ok  = 1'b0;
        keep_bit = c_reg.comp_sync[1];
        pwr_code = {c_reg.ctrl[`ADCCW_F_PWR_HI],
                    c_reg.ctrl[`ADCCW_F_PWR_LO]};

        // pins and link toggle pass two flops first
        c_next.addr_sync = {c_reg.addr_sync[0], package_addr_pin_i};
        c_next.comp_sync = {c_reg.comp_sync[0], comparator_i};
        c_next.tgl_sync  = {c_reg.tgl_sync[1:0], link_tgl};

        // mux follows the word during acquisition only
        if (!c_reg.hold) begin
            c_next.pos   = dec_pos;
            c_next.neg   = dec_neg;
            c_next.test  = dec_test;
            c_next.undoc = dec_undoc;
        end

        // reference follows the stored word at once
        c_next.ext_ref    = c_reg.ctrl[`ADCCW_F_EXT_VREF_SELECT];
        // partial power-down leaves the reference alive
        c_next.int_ref_en = ~c_reg.ctrl[`ADCCW_F_EXT_VREF_SELECT]
                            & ~c_reg.pd_full;

        // sequencer
        case (c_reg.seq)
            SEQ_ACQ: begin
                // comparator balanced, sampling capacitor tracks
                c_next.hold = 1'b0;
                c_next.busy = 1'b0;
            end
            SEQ_DELAY: begin
                // still acquiring; newest channel is what gets held
                if (c_reg.dly == 4'(`ADCCW_START_CYC - 1)) begin
                    c_next.seq     = SEQ_BIT;
                    c_next.hold    = 1'b1;
                    c_next.pos     = dec_pos;
                    c_next.neg     = dec_neg;
                    c_next.test    = dec_test;
                    c_next.undoc   = dec_undoc;
                    c_next.bit_idx = 4'h9;
                    c_next.trial   = `ADCCW_RES_MSB;
                    c_next.settle  = 2'h0;
                end else begin
                    c_next.dly = c_reg.dly + 4'h1;
                end
            end
            SEQ_BIT: begin
                // wait out DAC settling plus the comparator sync
                if (c_reg.settle == 2'(`ADCCW_BIT_CYC - 1)) begin
                    c_next.settle = 2'h0;
                    c_next.trial[c_reg.bit_idx] = keep_bit;
                    if (c_reg.bit_idx == 4'h0) begin
                        c_next.seq = SEQ_DONE;
                    end else begin
                        c_next.bit_idx = c_reg.bit_idx - 4'h1;
                        c_next.trial[c_reg.bit_idx - 4'h1] = 1'b1;
                    end
                end else begin
                    c_next.settle = c_reg.settle + 2'h1;
                end
            end
            SEQ_DONE: begin
                // straight binary code handed to the serial side
                c_next.result  = c_reg.trial;
                c_next.res_tgl = ~c_reg.res_tgl;
                c_next.hold    = 1'b0;
                c_next.busy    = 1'b0;
                c_next.seq     = SEQ_ACQ;
                c_next.ctrl[`ADCCW_F_START] = 1'b0;
                // equal codes leave the power state untouched
                if (pwr_code == `ADCCW_PWR_PART_EOC) begin
                    c_next.pd_part = 1'b1;
                end else if (pwr_code == `ADCCW_PWR_FULL_EOC) begin
                    c_next.pd_full = 1'b1;
                end
            end
            default: begin
                c_next.seq = SEQ_ACQ;
            end
        endcase

        // a word taken this cycle wins over the start-bit clear
        new_word = c_reg.tgl_sync[2] ^ c_reg.tgl_sync[1];
        addr_ok  = link_word[`ADCCW_F_ADDR] == c_reg.addr_sync[1];
        if (new_word) begin
            c_next.sel = addr_ok;
            if (addr_ok) begin
                c_next.ctrl = link_word;
                case ({link_word[`ADCCW_F_PWR_HI],
                       link_word[`ADCCW_F_PWR_LO]})
                    `ADCCW_PWR_DOWN_NOW: begin
                        c_next.pd_full = 1'b1;
                        c_next.pd_part = 1'b0;
                    end
                    default: begin
                        // up now; end-of-conversion codes act later
                        // a power-down set by this very end wins
                        if (c_reg.seq != SEQ_DONE) begin
                            c_next.pd_full = 1'b0;
                            c_next.pd_part = 1'b0;
                        end
                    end
                endcase
                // start only from acquisition; a busy core ignores it
                if (link_word[`ADCCW_F_START]
                    && c_reg.seq == SEQ_ACQ) begin
                    c_next.seq  = SEQ_DELAY;
                    c_next.dly  = 4'h0;
                    c_next.busy = 1'b1;
                end
            end
        end

        // power-down now overrides a pending start
        if (new_word && addr_ok
            && {link_word[`ADCCW_F_PWR_HI], link_word[`ADCCW_F_PWR_LO]}
               == `ADCCW_PWR_DOWN_NOW) begin
            c_next.seq  = SEQ_ACQ;
            c_next.hold = 1'b0;
            c_next.busy = 1'b0;
            c_next.ctrl[`ADCCW_F_START] = 1'b0;
        end
    end

    // single state register; everything zero after reset except full power-down, which is set
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            c_reg         <= '0;
            c_reg.ctrl    <= `ADCCW_CTRL_RST;
            c_reg.sel     <= 1'b0;
            c_reg.seq     <= SEQ_ACQ;
            c_reg.pd_full <= 1'b1;
        end else begin
            c_reg <= c_next;
        end
    end

    // outputs straight from the state register
    assign mux_pos_o            = c_reg.pos;
    assign mux_neg_o            = c_reg.neg;
    assign test_input_o         = c_reg.test;
    assign undoc_select_o       = c_reg.undoc;
    assign sample_hold_o        = c_reg.hold;
    assign dac_code_o           = c_reg.trial;
    assign conv_busy_o          = c_reg.busy;
    assign full_power_down_o    = c_reg.pd_full;
    assign partial_power_down_o = c_reg.pd_part;
    assign ext_vref_select_o    = c_reg.ext_ref;
    assign int_ref_enable_o     = c_reg.int_ref_en;

endmodule // adccw_top
`default_nettype wire

/* tb/adccw_chk.sv */
// Purpose: port checks on the control word decoder
// Assumes: core clock domain only; link side judged by the bench
// Notes:   bound to every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module adccw_chk (
    // core clock and reset
    input wire logic       clock_i,
    input wire logic       rst_i,
    // multiplexer and test selection
    input wire logic [3:0] mux_pos_o,
    input wire logic [3:0] mux_neg_o,
    input wire logic [1:0] test_input_o,
    input wire logic       undoc_select_o,
    // converter core
    input wire logic       sample_hold_o,
    input wire logic [9:0] dac_code_o,
    input wire logic       conv_busy_o,
    // power and reference
    input wire logic       full_power_down_o,
    input wire logic       partial_power_down_o,
    input wire logic       ext_vref_select_o,
    input wire logic       int_ref_enable_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // start delay, then the bit search up to the end of conversion
    sequence s_delay;
        ##10 $rose(sample_hold_o);
    endsequence
    sequence s_search;
        ##[28:34] $fell(conv_busy_o);
    endsequence

    property p_rst_vals;
        $fell(rst_i) |-> full_power_down_o && !partial_power_down_o
            && !conv_busy_o && !int_ref_enable_o;
    endproperty
    property p_start_delay; $rose(conv_busy_o) |-> s_delay; endproperty
    property p_search_len; $rose(sample_hold_o) |-> s_search; endproperty
    property p_dac_msb;
        $rose(sample_hold_o) |-> dac_code_o == 10'h200;
    endproperty
    property p_hold_busy; sample_hold_o |-> conv_busy_o; endproperty
    // a late mux change would corrupt the held sample
    property p_mux_frozen;
        sample_hold_o && $past(sample_hold_o)
            |-> $stable(mux_pos_o) && $stable(mux_neg_o);
    endproperty
    property p_ext_ref;
        ext_vref_select_o && $past(ext_vref_select_o) |-> !int_ref_enable_o;
    endproperty
    property p_part_eoc;
        $rose(partial_power_down_o) |-> $fell(conv_busy_o);
    endproperty
    property p_neg_even;
        mux_neg_o != 4'h0 |-> !mux_neg_o[0] && mux_neg_o > mux_pos_o;
    endproperty
    property p_undoc;
        undoc_select_o |-> mux_pos_o == 4'h0 && test_input_o == 2'h0;
    endproperty
    property p_test_sel;
        test_input_o != 2'h0 |-> mux_pos_o == 4'h0 && mux_neg_o == 4'h0;
    endproperty

    a_rst_vals: assert property (p_rst_vals)
        else $error("bad values after reset");
    a_start_delay: assert property (p_start_delay)
        else $error("hold not 10 cycles after start");
    a_search_len: assert property (p_search_len)
        else $error("search length wrong");
    a_dac_msb: assert property (p_dac_msb)
        else $error("first trial code wrong");
    a_hold_busy: assert property (p_hold_busy)
        else $error("hold outside conversion");
    a_mux_frozen: assert property (p_mux_frozen)
        else $error("mux moved during hold");
    a_ext_ref: assert property (p_ext_ref)
        else $error("internal ref on with external ref");
    a_part_eoc: assert property (p_part_eoc)
        else $error("partial power-down not at end");
    a_neg_even: assert property (p_neg_even)
        else $error("negative input wrong");
    a_undoc: assert property (p_undoc)
        else $error("undefined code selects an input");
    a_test_sel: assert property (p_test_sel)
        else $error("test input with mux input");
endmodule // adccw_chk

bind adccw_top adccw_chk u_chk (
    .clock_i, .rst_i, .mux_pos_o, .mux_neg_o, .test_input_o,
    .undoc_select_o, .sample_hold_o, .dac_code_o, .conv_busy_o,
    .full_power_down_o, .partial_power_down_o, .ext_vref_select_o,
    .int_ref_enable_o
);
`default_nettype wire

/* tb/adccw_host.sv */
// Purpose: serial host model driving the control port
// Assumes: link clock runs during reset and within frames only
// Notes:   a released data line reads as a toggling level
`timescale 1ns/10ps
`default_nettype none
module adccw_host (
    // clock, frame and command data to the devices
    output logic            sclk_o,
    output logic            frame_sync_n_o,
    output logic            sdata_o,
    // result data and enables from the devices
    input  wire logic [1:0] sdata_i,
    input  wire logic [1:0] sdata_oe_i
);
    logic run  = 1'b1;
    logic last = 1'b0;
    logic line;

    // idle levels
    initial begin
        sclk_o = 1'b0;
        frame_sync_n_o = 1'b1;
        sdata_o = 1'b0;
    end
    // no keeper: an undriven line never repeats its last bit
    assign line = sdata_oe_i[0] ? sdata_i[0]
                : sdata_oe_i[1] ? sdata_i[1] : ~last;
    always @(negedge sclk_o) last <= line;
    // link clock, 64 ns period, stopped between frames
    always #32 if (run) sclk_o = ~sclk_o;

    // one frame: ten bits out and ten bits in, msb first
    task automatic xfer(input logic [9:0] w, output logic [9:0] r,
                        output logic [1:0] oe_any);
        oe_any = 2'b00;
        run = 1'b1;
        repeat (4) @(negedge sclk_o);
        frame_sync_n_o = 1'b0;
        for (int k = 9; k >= 0; k--) begin
            sdata_o = w[k];
            @(negedge sclk_o);
            r[k] = line;
            oe_any = oe_any | sdata_oe_i;
        end
        frame_sync_n_o = 1'b1;
        sdata_o = ~sdata_o;
        repeat (2) @(negedge sclk_o);
        run = 1'b0;
    endtask
endmodule // adccw_host
`default_nettype wire

/* tb/testbench.sv */
// Purpose: self-checking bench for the control word decoder
// Assumes: two devices share one serial bus at addresses 0 and 1
// Notes:   the second device is the four-channel variant
`timescale 1ns/10ps
`default_nettype none
module testbench import adccw_pkg::*;;
    logic             clock_i = 1'b0;
    logic             rst_i   = 1'b1;
    logic [9:0]       vin     = 10'h000;
    logic [9:0]       rd;
    logic [1:0]       oe_any;
    logic [1:0]       sel     = 2'b00;
    logic [10:0]      exp_cfg;
    int               bad_count = 0;
    int               comparisons = 0;
    wire logic        sclk, fsn, sdi, hold, busy, fpd, ppd, extr, iref;
    wire logic [1:0]  sdo, soe, und;
    wire logic [9:0]  dac;
    wire logic [1:0][3:0] pos, neg;
    wire logic [1:0][1:0] tst;
    wire logic        cmp = vin >= dac;

    always #20 clock_i = ~clock_i;

    // eight-channel device at address 0, four-channel at address 1
    adccw_top #(.QUAD(1'b0)) dut (
        .clock_i, .rst_i, .sclk_i(sclk), .frame_sync_n_i(fsn),
        .sdata_i(sdi), .sdata_o(sdo[0]), .sdata_oe_o(soe[0]),
        .package_addr_pin_i(1'b0), .comparator_i(cmp),
        .mux_pos_o(pos[0]), .mux_neg_o(neg[0]), .test_input_o(tst[0]),
        .undoc_select_o(und[0]), .sample_hold_o(hold), .dac_code_o(dac),
        .conv_busy_o(busy), .full_power_down_o(fpd),
        .partial_power_down_o(ppd), .ext_vref_select_o(extr),
        .int_ref_enable_o(iref));
    adccw_top #(.QUAD(1'b1)) dut_quad (
        .clock_i, .rst_i, .sclk_i(sclk), .frame_sync_n_i(fsn),
        .sdata_i(sdi), .sdata_o(sdo[1]), .sdata_oe_o(soe[1]),
        .package_addr_pin_i(1'b1), .comparator_i(1'b0),
        .mux_pos_o(pos[1]), .mux_neg_o(neg[1]), .test_input_o(tst[1]),
        .undoc_select_o(und[1]), .sample_hold_o(), .dac_code_o(),
        .conv_busy_o(), .full_power_down_o(), .partial_power_down_o(),
        .ext_vref_select_o(), .int_ref_enable_o());
    adccw_host host (.sclk_o(sclk), .frame_sync_n_o(fsn), .sdata_o(sdi),
        .sdata_i(sdo), .sdata_oe_i(soe));

    task automatic check(input logic [10:0] seen, input logic [10:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic summarize();
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one frame; only the last addressed device may drive data
    task automatic wr(input logic [9:0] w);
        host.xfer(w, rd, oe_any);
        check(11'(oe_any), 11'(sel));
        sel = w[9] ? 2'b10 : 2'b01;
        repeat (8) @(posedge clock_i);
        #1;
    endtask

    // expected {pos, neg, test, undoc} for a channel setting
    function automatic logic [10:0] dec(input bit q, input logic cm_sel,
                                        input logic pair,
                                        input logic [2:0] ch);
        logic [3:0] cm;
        logic [3:0] c4;
        cm = q ? 4'h4 : 4'h8;
        c4 = {1'b0, ch};
        if (!pair && !(cm_sel && c4 == cm - 4'h1))
            return {c4 + 4'h1, cm_sel ? cm : 4'h0, 3'h0};
        if (pair && c4 < cm / 2)
            return {ch, 1'b1, ch + 3'h1, 1'b0, 3'h0};
        if (pair && c4 == cm / 2)
            return 11'h002;
        if (pair && c4 == cm / 2 + 4'h1)
            return 11'h004;
        return 11'h001;
    endfunction

    initial begin
        repeat (6) @(posedge clock_i);
        #1 rst_i = 1'b0;
        check(11'({fpd, ppd, busy, iref}), 11'h8);
        // every channel code of both variants; eight-channel device checked unchanged during quad writes
        for (int q = 0; q < 2; q++)
            for (int m = 0; m < 4; m++)
                for (int c = 0; c < 8 - 4 * q; c++) begin
                    wr(q ? {1'b1, 2'h3, m[1:0], 1'b1, 2'(c), 2'h0}
                         : {1'b0, 2'h3, m[1:0], 3'(c), 2'h0});
                    if (q == 0)
                        exp_cfg = dec(1'b0, m[1], m[0], 3'(c));
                    check({pos[0], neg[0], tst[0], und[0]}, exp_cfg);
                    if (q == 1)
                        check({pos[1], neg[1], tst[1], und[1]},
                              dec(1'b1, m[1], m[0], 3'(c)));
                end
        // conversion under each non-immediate power code
        for (int p = 1; p < 4; p++) begin
            vin = 10'h0c3 + 10'(p * 211);
            wr({1'b0, 2'(p), 2'h0, 3'(p + 2), 2'h3});
            check(11'({busy, ppd, fpd}), 11'h4);
            // look just past each edge, never in the edge's own step
            for (int n = 0; n < 80 && busy !== 1'b0; n++) begin
                @(posedge clock_i);
                #1;
            end
            check(11'(busy), 11'h0);
            repeat (2) @(posedge clock_i);
            #1;
            check(11'({pos[0], extr, iref, ppd, fpd}),
                  11'({4'(p + 3), 2'b10, p == 1, p == 2}));
            repeat (20) @(posedge clock_i);
            #1;
            check(11'(busy), 11'h0);
            wr({1'b0, 2'h3, 2'h0, 3'(p + 2), 2'h1});
            check(11'(rd), 11'(vin));
        end
        wr(10'h000);
        check(11'({fpd, iref}), 11'h2);
        summarize();
    end

    // hang guard, far beyond the expected run of about 77 us
    initial begin
        #500000;
        bad_count++;
        summarize();
    end
endmodule // testbench
`default_nettype wire
